// ### sqe_pkg.sv
package sqe_pkg;
   // ----------------------------------------
   // resolution and angle
   // ----------------------------------------
   localparam int ANG_W = 16;
   localparam logic [14:0] RES_MIN = 15'h0040;
   localparam logic [14:0] RES_MAX = 15'h4000;
   localparam logic [14:0] RES_RST = 15'h0400;
   localparam int RES_W = 15;
   // ----------------------------------------
   // command decoder states
   // ----------------------------------------
   typedef enum logic [1:0] {
      SQE_IDLE = 2'b01,
      SQE_LOAD = 2'b10
   } sqe_cmd_t;
endpackage : sqe_pkg

// ### sqe_quad.sv
// ----------------------------------------
// angle to quadrature phase converter
// ----------------------------------------
module sqe_quad (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // angle and scale
   input wire logic [sqe_pkg::ANG_W-1:0] angle,
   input wire logic [sqe_pkg::RES_W-1:0] res,
   // quarter-period index
   output logic [sqe_pkg::RES_W+1:0] pos_r
);
   import sqe_pkg::*;
   // quarter-cycle count = angle * res * 4 / 2^16
   localparam int PW = ANG_W + RES_W + 2;
   wire logic [PW-1:0] prod;
   assign prod = PW'(angle) * PW'({res, 2'b00});
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pos_r <= '0;
      end else begin
         pos_r <= prod[ANG_W+RES_W+1:ANG_W];
      end
   end
endmodule : sqe_quad

// ### sqe_encoder.sv
// Contract
// - two channels, 64 to 16384 pulses per revolution
// - channel b leads a by 90 deg CW
// - one marker pulse per electrical revolution
// - strobed parallel command sets pulse resolution
module sqe_encoder (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // resolver angle, electrical
   input wire logic [sqe_pkg::ANG_W-1:0] angle,
   // resolution command
   input wire logic pulse_resolution_command,
   input wire logic [sqe_pkg::RES_W-1:0] cmd_res,
   output logic cmd_refused,
   output logic [sqe_pkg::RES_W-1:0] res_r,
   // encoder outputs
   output logic enc_a_r,
   output logic enc_b_r,
   output logic enc_c_r,
   output logic enc_a_n_r,
   output logic enc_b_n_r,
   output logic enc_c_n_r
);
   import sqe_pkg::*;
   // ----------------------------------------
   // input synchroniser for angle
   // ----------------------------------------
   logic [ANG_W-1:0] ang_s1_r;
   logic [ANG_W-1:0] ang_s2_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ang_s1_r <= '0;
         ang_s2_r <= '0;
      end else begin
         ang_s1_r <= angle;
         ang_s2_r <= ang_s1_r;
      end
   end
   // ----------------------------------------
   // resolution command
   // ----------------------------------------
   function automatic logic res_ok(input logic [RES_W-1:0] r);
      res_ok = (r >= RES_MIN) && (r <= RES_MAX);
   endfunction : res_ok
   sqe_cmd_t st_r;
   sqe_cmd_t st_nxt;
   logic [RES_W-1:0] res_nxt;
   wire logic cmd_good;
   assign cmd_good = res_ok(cmd_res);
   assign cmd_refused = pulse_resolution_command && !cmd_good;
   always_comb begin
      st_nxt = st_r;
      res_nxt = res_r;
      unique case (st_r)
         SQE_IDLE: begin
            if (pulse_resolution_command && cmd_good) begin
               st_nxt = SQE_LOAD;
               res_nxt = cmd_res;
            end
         end
         SQE_LOAD: begin
            st_nxt = SQE_IDLE;
         end
         default: begin
            st_nxt = SQE_IDLE;
         end
      endcase
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= SQE_IDLE;
         res_r <= RES_RST;
      end else begin
         st_r <= st_nxt;
         res_r <= res_nxt;
      end
   end
   // ----------------------------------------
   // quadrature generation
   // ----------------------------------------
   logic [RES_W+1:0] pos;
   sqe_quad u_quad (
      .mclk(mclk),
      .rst_n(rst_n),
      .angle(ang_s2_r),
      .res(res_r),
      .pos_r(pos)
   );
   // gray of quarter index: CW (rising angle) makes b lead a
   wire logic a_nxt;
   wire logic b_nxt;
   wire logic c_nxt;
   assign b_nxt = ~pos[1];
   assign a_nxt = pos[1] ^ pos[0];
   // marker only in first quarter-period (pos zero) of electrical revolution
   assign c_nxt = (pos == '0);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         enc_a_r <= 1'b0;
         enc_b_r <= 1'b1;
         enc_c_r <= 1'b0;
         enc_a_n_r <= 1'b1;
         enc_b_n_r <= 1'b0;
         enc_c_n_r <= 1'b1;
      end else begin
         enc_a_r <= a_nxt;
         enc_b_r <= b_nxt;
         enc_c_r <= c_nxt;
         enc_a_n_r <= ~a_nxt;
         enc_b_n_r <= ~b_nxt;
         enc_c_n_r <= ~c_nxt;
      end
   end
endmodule : sqe_encoder

// ### sqe_encoder_assertions.sv
module sqe_chk(input wire logic mclk,rst_n,pulse_resolution_command,cmd_refused,enc_a_r,enc_b_r,enc_c_r,
enc_a_n_r,enc_b_n_r,enc_c_n_r,input wire logic [14:0] cmd_res,res_r);
timeunit 1ns/1ns;
default clocking @(posedge mclk); endclocking
default disable iff (!rst_n);
a_inv_copy: assert property ({enc_a_n_r,enc_b_n_r,enc_c_n_r}==~{enc_a_r,enc_b_r,enc_c_r}) else $error("inv");
a_res_ok: assert property (res_r>=64&&res_r<=16384) else $error("res");
a_cmd_load: assert property ($rose(pulse_resolution_command)&&!cmd_refused|=>res_r==$past(cmd_res))
else $error("ld");
a_mark_q0: assert property (enc_c_r|->!enc_a_r&&enc_b_r) else $error("mark");
a_quad_gray: assert property (!($changed(enc_a_r)&&$changed(enc_b_r))) else $error("gray");
c_mark: cover property ($rose(enc_c_r));
c_ref: cover property (cmd_refused);
c_load: cover property ($changed(res_r));
endmodule : sqe_chk
bind sqe_encoder sqe_chk u_chk(.*);

// ### sqe_cnc.sv
module sqe_cnc(input wire logic mclk,a,b,c,output int pos,marks);
timeunit 1ns/1ns;
logic pa=0,pb=1,pc=0;
// brake held clamped: runs are far shorter than its release intervals, never moved in motion
logic brake_rel=1'b0;
always @(posedge mclk) begin
if({a,b}!={pa,pb}) pos<=pos+(a==pb?1:-1);
if(c&&!pc) marks<=marks+1;
{pa,pb,pc}<={a,b,c};
end
endmodule : sqe_cnc

// ### sqe_encoder_test.sv
module sqe_encoder_test;
timeunit 1ns/1ns;
logic mclk=0,rst_n=0,go=0,enc_a_r,enc_b_r,enc_c_r,enc_a_n_r,enc_b_n_r,enc_c_n_r,cmd_refused;
logic [15:0] angle=0;
logic [14:0] cmd_res=0,res_r;
int fail_count,total_checks,exp_res=1024,pos,marks,sd=84;
sqe_encoder u_dut(.*,.pulse_resolution_command(go));
sqe_cnc u_cnc(.mclk,.a(enc_a_r),.b(enc_b_r),.c(enc_c_r),.pos,.marks);
// {a,b} per quarter of a line for rising angle: b leads a
localparam logic [1:0] AB_SEQ [4] = '{2'b01,2'b11,2'b10,2'b00};
int aq[$];
// angle history: outputs trail the sampled angle by three edges
always @(posedge mclk) begin
aq.push_back(int'(angle));
if(aq.size()>4) void'(aq.pop_front());
end
function int rnd(); sd^=sd<<13; sd^=sd>>17; sd^=sd<<5; return sd; endfunction : rnd
task chk(input logic [31:0] s,e); total_checks++;
if(s!==e) begin fail_count++; $display("CHECK FAILED %0t %h %h",$time,s,e); end endtask : chk
task results(); $display("fail_count %0d total_checks %0d",fail_count,total_checks);
if(fail_count==0&&total_checks>0) $display("Regression OK");
else $display("Regression broken");
$finish; endtask : results
task send(input int v); @(posedge mclk) go<=1;
cmd_res<=15'(v); #1 chk(cmd_refused,v<64||v>16384);
@(posedge mclk) go<=0; if(v>=64&&v<=16384) exp_res=v;
#1 chk(res_r,exp_res); endtask : send
task enc_chk(); longint q; logic [2:0] ex; logic [2:0] exn;
q=(longint'(aq[0])*exp_res*4)>>16;
ex={AB_SEQ[q%4],q==0};
exn=~ex;
chk({enc_a_r,enc_b_r,enc_c_r},ex);
chk({enc_a_n_r,enc_b_n_r,enc_c_n_r},exn); endtask : enc_chk
task rev(input int d,p,m); repeat(1024) begin @(posedge mclk) angle<=angle+16'(d); #1 enc_chk(); end
#400 chk(pos,p);
chk(marks,m); endtask : rev
initial forever #25 mclk=~mclk;
initial begin #200000 fail_count++; results(); end
initial begin repeat(3) @(posedge mclk); rst_n<=1;
send(63); send(16384); repeat(3) send(64+(rnd()&14'h3fff));
send(64); rev(64,256,2); rev(-64,0,3); results(); end
endmodule : sqe_encoder_test
